// ---- core/seq_ctrl_pkg.sv ----
// shared constants for the serial sequence control register logic
package seq_ctrl_pkg;

    // register offset on the parallel host port
    localparam logic [7:0] CTRL_OFFSET       = 8'hE0;

    // bit positions inside the control register
    localparam int         HALT_SEQ_POS      = 7;
    localparam int         LAUNCH_POS        = 6;
    localparam int         HALT_BYTE_POS     = 5;
    localparam int         EDGE_SEL_POS      = 4;
    localparam int         TRIG_EN_POS       = 3;
    localparam int         BYTE_PTR_CLR_POS  = 2;
    localparam int         TABLE_PTR_CLR_POS = 1;

    // reset values
    localparam logic [7:0] CTRL_RESET        = 8'h00;
    localparam logic       BIT_RESET         = 1'b0;
    localparam logic [7:0] READ_IDLE         = 8'h00;

    // loop repeat count encodings
    localparam logic [7:0] LOOP_FOREVER      = 8'h00;
    localparam logic [7:0] LOOP_STEP         = 8'h01;

    // channel sequencing states
    typedef enum logic [2:0] {
        S_IDLE,
        S_WAIT_TRIG,
        S_RUN,
        S_GAP,
        S_ENDING
    } chan_state_t;

endpackage

// ---- core/sync3_edge.sv ----
// three-stage input synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module sync3_edge (
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // asynchronous input
    input  wire logic din,
    // filtered level and one-cycle edge pulses
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic stable_q;
    logic rise_q;
    logic fall_q;

    // plain shift chain; first stage feeds only the second
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stable_q <= 1'b0;
            rise_q   <= 1'b0;
            fall_q   <= 1'b0;
        end else begin
            rise_q <= 1'b0;
            fall_q <= 1'b0;
            if ((s2_q == s3_q) && (s3_q != stable_q)) begin
                stable_q <= s3_q;
                rise_q   <= s3_q;
                fall_q   <= ~s3_q;
            end
        end
    end

    assign level = stable_q;
    assign rise  = rise_q;
    assign fall  = fall_q;

endmodule

// ---- core/serial_sequence_control.sv ----
// control register and sequence launch/halt logic for the serial channel
`timescale 1ns/1ps
module serial_sequence_control
    import seq_ctrl_pkg::*;
(
    // clocks and reset
    input  wire logic       ref_clk,
    input  wire logic       link_clk,
    input  wire logic       rstn,
    // parallel host port, ref_clk domain
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rd_data,
    // settings held by neighbouring registers, ref_clk domain
    input  wire logic       channel_on_bit,
    input  wire logic [7:0] loop_repeat_count,
    // external trigger pin
    input  wire logic       trigger_in,
    // pointer control toward the buffer logic
    output logic            byte_count_pointer_clear,
    output logic            table_pointer_clear,
    // channel state
    output logic            channel_active,
    // bit engine, link_clk domain
    input  wire logic       byte_done,
    input  wire logic       seq_done,
    input  wire logic       stop_seen,
    output logic            start_cmd,
    output logic            halt_byte_cmd,
    output logic            halt_seq_cmd
);

    chan_state_t state_q;

    logic       sequence_launch_bit_q;
    logic       halt_after_byte_bit_q;
    logic       halt_after_sequence_bit_q;
    logic       trigger_edge_select_q;
    logic       trigger_input_enable_q;
    logic       halt_seq_eff_q;
    logic [7:0] seq_cnt_q;
    logic       start_tgl_q;
    logic [7:0] rd_data_q;
    logic       byte_ptr_clr_q;
    logic       table_ptr_clr_q;
    logic       active_q;

    // link side state
    logic       byte_tgl_lk_q;
    logic       seq_tgl_lk_q;
    logic       stop_tgl_lk_q;
    logic       start_cmd_q;
    logic       halt_byte_s1_q;
    logic       halt_byte_cmd_q;
    logic       halt_seq_s1_q;
    logic       halt_seq_cmd_q;

    // decoded strobes and decisions
    logic       ctrl_wr;
    logic       launch_accept;
    logic       halt_byte_set;
    logic       halt_seq_set;
    logic       halt_any;
    logic       trig_en_nx;
    logic       trig_tick;
    logic       launch_drop;
    logic       start_go;
    logic       last_seq;

    // synchronised events and trigger edges
    logic       trig_rise;
    logic       trig_fall;
    logic       byte_rise;
    logic       byte_fall;
    logic       seq_rise;
    logic       seq_fall;
    logic       stop_rise;
    logic       stop_fall;
    logic       start_rise;
    logic       start_fall;
    logic       ev_byte;
    logic       ev_seq;
    logic       ev_stop;

    // true when the sequence just finished is the last of a counted run
    function automatic logic is_last_loop(input logic [7:0] count, input logic [7:0] done);
        logic [7:0] next_done;
        next_done    = 8'(done + LOOP_STEP);
        is_last_loop = (count != LOOP_FOREVER) && (next_done == count);
    endfunction

    // ------------------------------------------------------------------
    // crossings into ref_clk
    // ------------------------------------------------------------------

    // trigger pin through three stages
    sync3_edge u_trig_sync (
        .clk  (ref_clk),
        .rstn (rstn),
        .din  (trigger_in),
        .level(),
        .rise (trig_rise),
        .fall (trig_fall)
    );

    // engine events arrive as toggles; either edge is one event
    sync3_edge u_byte_sync (
        .clk  (ref_clk),
        .rstn (rstn),
        .din  (byte_tgl_lk_q),
        .level(),
        .rise (byte_rise),
        .fall (byte_fall)
    );

    sync3_edge u_seq_sync (
        .clk  (ref_clk),
        .rstn (rstn),
        .din  (seq_tgl_lk_q),
        .level(),
        .rise (seq_rise),
        .fall (seq_fall)
    );

    sync3_edge u_stop_sync (
        .clk  (ref_clk),
        .rstn (rstn),
        .din  (stop_tgl_lk_q),
        .level(),
        .rise (stop_rise),
        .fall (stop_fall)
    );

    assign ev_byte = byte_rise | byte_fall;
    assign ev_seq  = seq_rise | seq_fall;
    assign ev_stop = stop_rise | stop_fall;

    // ------------------------------------------------------------------
    // host write decode
    // ------------------------------------------------------------------

    assign ctrl_wr       = wr_en && (addr == CTRL_OFFSET);
    // launch only from idle with the channel switched on
    assign launch_accept = ctrl_wr && wr_data[LAUNCH_POS] && channel_on_bit
                           && (state_q == S_IDLE);
    // halt requests only count while a launch is pending
    assign halt_byte_set = ctrl_wr && wr_data[HALT_BYTE_POS] && sequence_launch_bit_q;
    assign halt_seq_set  = ctrl_wr && wr_data[HALT_SEQ_POS] && sequence_launch_bit_q;
    assign halt_any      = halt_after_byte_bit_q | halt_after_sequence_bit_q;
    // the launch write may carry new trigger setup in the same cycle
    assign trig_en_nx    = ctrl_wr ? wr_data[TRIG_EN_POS] : trigger_input_enable_q;
    // pick the edge; everything is masked while triggering is off
    assign trig_tick     = trigger_input_enable_q
                           && (trigger_edge_select_q ? trig_fall : trig_rise);
    // counted runs end on the last loop; trigger mode never counts
    assign last_seq      = ~trigger_input_enable_q
                           && is_last_loop(loop_repeat_count, seq_cnt_q);

    // sequencing decisions
    always_comb begin
        launch_drop = 1'b0;
        start_go    = 1'b0;
        unique case (state_q)
            S_IDLE: begin
                start_go = launch_accept && !trig_en_nx;
            end
            S_WAIT_TRIG: begin
                // halting while waiting for a tick ends at once, no stop pending
                if (halt_any) begin
                    launch_drop = 1'b1;
                end else begin
                    start_go = trig_tick;
                end
            end
            S_RUN: begin
                // byte halt is checked first so it wins over sequence halt
                if (ev_byte && halt_after_byte_bit_q) begin
                    launch_drop = 1'b1;
                end else if (ev_seq && (halt_any || last_seq)) begin
                    launch_drop = 1'b1;
                end
            end
            S_GAP: begin
                if (halt_any) begin
                    launch_drop = 1'b1;
                end else begin
                    start_go = ev_stop && !trigger_input_enable_q;
                end
            end
            S_ENDING: begin
                launch_drop = 1'b0;
            end
        endcase
    end

    // channel state
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= S_IDLE;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    // a tick in the launch cycle is ignored: we only arm here
                    if (launch_accept) begin
                        state_q <= trig_en_nx ? S_WAIT_TRIG : S_RUN;
                    end
                end
                S_WAIT_TRIG: begin
                    if (launch_drop) begin
                        state_q <= S_IDLE;
                    end else if (start_go) begin
                        state_q <= S_RUN;
                    end
                end
                S_RUN: begin
                    if (launch_drop) begin
                        state_q <= S_ENDING;
                    end else if (ev_seq) begin
                        state_q <= S_GAP;
                    end
                end
                S_GAP: begin
                    if (launch_drop) begin
                        state_q <= S_ENDING;
                    end else if (ev_stop) begin
                        state_q <= trigger_input_enable_q ? S_WAIT_TRIG : S_RUN;
                    end
                end
                S_ENDING: begin
                    // active until the closing stop is seen on the bus
                    if (ev_stop) begin
                        state_q <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // launch bit: set from idle only, cleared by the sequencer
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sequence_launch_bit_q <= BIT_RESET;
        end else if (launch_accept) begin
            sequence_launch_bit_q <= 1'b1;
        end else if (launch_drop) begin
            sequence_launch_bit_q <= 1'b0;
        end
    end

    // halt bits: a new set wins over a stop seen in the same cycle
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            halt_after_byte_bit_q     <= BIT_RESET;
            halt_after_sequence_bit_q <= BIT_RESET;
        end else begin
            if (halt_byte_set) begin
                halt_after_byte_bit_q <= 1'b1;
            end else if (ev_stop || (state_q == S_WAIT_TRIG && launch_drop)) begin
                halt_after_byte_bit_q <= 1'b0;
            end
            if (halt_seq_set) begin
                halt_after_sequence_bit_q <= 1'b1;
            end else if (ev_stop || (state_q == S_WAIT_TRIG && launch_drop)) begin
                halt_after_sequence_bit_q <= 1'b0;
            end
        end
    end

    // registered halt-after-sequence with byte halt taking priority
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            halt_seq_eff_q <= 1'b0;
        end else begin
            halt_seq_eff_q <= halt_after_sequence_bit_q & ~halt_after_byte_bit_q;
        end
    end

    // trigger setup frozen while active; host is expected not to try
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            trigger_edge_select_q  <= BIT_RESET;
            trigger_input_enable_q <= BIT_RESET;
        end else if (ctrl_wr && state_q == S_IDLE) begin
            trigger_edge_select_q  <= wr_data[EDGE_SEL_POS];
            trigger_input_enable_q <= wr_data[TRIG_EN_POS];
        end
    end

    // sequences completed in the current counted run
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            seq_cnt_q <= CTRL_RESET;
        end else if (launch_accept) begin
            seq_cnt_q <= CTRL_RESET;
        end else if (state_q == S_RUN && ev_seq) begin
            seq_cnt_q <= 8'(seq_cnt_q + LOOP_STEP);
        end
    end

    // start requests cross as a toggle; only issued with launch set or in the cycle a launch is accepted
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            start_tgl_q <= 1'b0;
        end else if (start_go) begin
            start_tgl_q <= ~start_tgl_q;
        end
    end

    // write-only pointer clears become one-cycle pulses
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            byte_ptr_clr_q  <= 1'b0;
            table_ptr_clr_q <= 1'b0;
        end else begin
            byte_ptr_clr_q  <= ctrl_wr && wr_data[BYTE_PTR_CLR_POS];
            table_ptr_clr_q <= ctrl_wr && wr_data[TABLE_PTR_CLR_POS];
        end
    end

    // read path; the write-only and reserved bits read as zero
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rd_data_q <= READ_IDLE;
        end else if (rd_en && addr == CTRL_OFFSET) begin
            rd_data_q <= {halt_after_sequence_bit_q, sequence_launch_bit_q,
                          halt_after_byte_bit_q, trigger_edge_select_q,
                          trigger_input_enable_q, 3'b000};
        end else begin
            rd_data_q <= READ_IDLE;
        end
    end

    // active flag for neighbouring logic
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            active_q <= 1'b0;
        end else begin
            active_q <= (state_q != S_IDLE);
        end
    end

    // ------------------------------------------------------------------
    // link_clk side
    // ------------------------------------------------------------------

    // engine pulses become toggles so no event is lost across domains
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            byte_tgl_lk_q <= 1'b0;
            seq_tgl_lk_q  <= 1'b0;
            stop_tgl_lk_q <= 1'b0;
        end else begin
            byte_tgl_lk_q <= byte_tgl_lk_q ^ byte_done;
            seq_tgl_lk_q  <= seq_tgl_lk_q ^ seq_done;
            stop_tgl_lk_q <= stop_tgl_lk_q ^ stop_seen;
        end
    end

    // start toggle received on the link clock
    sync3_edge u_start_sync (
        .clk  (link_clk),
        .rstn (rstn),
        .din  (start_tgl_q),
        .level(),
        .rise (start_rise),
        .fall (start_fall)
    );

    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            start_cmd_q <= 1'b0;
        end else begin
            start_cmd_q <= start_rise | start_fall;
        end
    end

    // halt levels: two stages; engine keeps error reporting to the last bit
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            halt_byte_s1_q  <= 1'b0;
            halt_byte_cmd_q <= 1'b0;
            halt_seq_s1_q   <= 1'b0;
            halt_seq_cmd_q  <= 1'b0;
        end else begin
            halt_byte_s1_q  <= halt_after_byte_bit_q;
            halt_byte_cmd_q <= halt_byte_s1_q;
            halt_seq_s1_q   <= halt_seq_eff_q;
            halt_seq_cmd_q  <= halt_seq_s1_q;
        end
    end

    assign rd_data                  = rd_data_q;
    assign byte_count_pointer_clear = byte_ptr_clr_q;
    assign table_pointer_clear      = table_ptr_clr_q;
    assign channel_active           = active_q;
    assign start_cmd                = start_cmd_q;
    assign halt_byte_cmd            = halt_byte_cmd_q;
    assign halt_seq_cmd             = halt_seq_cmd_q;

    // ------------------------------------------------------------------
    // checks, ref_clk domain
    // ------------------------------------------------------------------

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    launch_refused_a: assert property (ctrl_wr && wr_data[LAUNCH_POS]
        && !channel_on_bit && !sequence_launch_bit_q |=> !sequence_launch_bit_q)
        else $error("launch accepted with channel off");

    no_start_idle_a: assert property (start_go |-> (sequence_launch_bit_q || launch_accept))
        else $error("start requested without launch");

    byte_halt_end_a: assert property (state_q == S_RUN && ev_byte
        && halt_after_byte_bit_q |=> !sequence_launch_bit_q && state_q == S_ENDING)
        else $error("byte halt did not end the run");

    seq_halt_end_a: assert property (state_q == S_RUN && ev_seq
        && halt_after_sequence_bit_q && !ev_byte
        |=> !sequence_launch_bit_q ##1 $stable(start_tgl_q))
        else $error("sequence halt did not end the run");

    halt_discard_a: assert property (!sequence_launch_bit_q && !halt_after_byte_bit_q
        && ctrl_wr && wr_data[HALT_BYTE_POS] |=> !halt_after_byte_bit_q)
        else $error("halt write accepted with launch clear");

    stop_clears_a: assert property (ev_stop && !halt_byte_set
        |=> !halt_after_byte_bit_q)
        else $error("stop did not clear byte halt");

    tick_starts_a: assert property (state_q == S_WAIT_TRIG && !halt_any && trig_tick
        |=> state_q == S_RUN && start_tgl_q != $past(start_tgl_q))
        else $error("trigger tick did not start a sequence");

    launch_arms_a: assert property (launch_accept && trig_en_nx
        |=> state_q == S_WAIT_TRIG && $stable(start_tgl_q))
        else $error("trigger in launch cycle was used");

    trig_masked_a: assert property (!trigger_input_enable_q && state_q != S_IDLE
        |-> !trig_tick && state_q != S_WAIT_TRIG)
        else $error("trigger acted while disabled");

    single_loop_a: assert property (state_q == S_RUN && ev_seq && !ev_byte
        && !halt_any && !trigger_input_enable_q && loop_repeat_count == LOOP_STEP
        |=> !sequence_launch_bit_q)
        else $error("single sequence left launch set");

    setup_locked_a: assert property (state_q != S_IDLE && ctrl_wr
        |=> $stable(trigger_input_enable_q) && $stable(trigger_edge_select_q))
        else $error("trigger setup changed while active");

    ptr_pulse_a: assert property (ctrl_wr && wr_data[BYTE_PTR_CLR_POS]
        |=> byte_count_pointer_clear)
        else $error("byte pointer clear not pulsed");

    readback_zero_a: assert property (rd_en |=> rd_data[2:0] == 3'b000)
        else $error("write-only bits read as one");

endmodule

// ---- sim/engine_model.sv ----
// bit engine model: one byte, sequence end unless halted after the byte, and stop for each start
`timescale 1ns/1ps
module engine_model (
    // link clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // commands from the control logic
    input  wire logic start_cmd,
    input  wire logic halt_byte_cmd,
    // engine events
    output logic      byte_done,
    output logic      seq_done,
    output logic      stop_seen
);
    logic [3:0] step_q;
    // one link cycle a step (five ref_clk cycles), so same-kind events stay far apart
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            step_q <= 4'h0;
        else if (start_cmd)
            step_q <= 4'h1;
        else if (step_q == 4'h5 && halt_byte_cmd)
            step_q <= 4'hB; // skip the rest, stop after this byte
        else if (step_q != 4'h0)
            step_q <= step_q + 4'h1;
    end
    // event pulses decoded from the step
    assign byte_done = step_q == 4'h4;
    assign seq_done  = step_q == 4'h8;
    assign stop_seen = step_q == 4'hB;
endmodule

// ---- sim/serial_sequence_control_tb.sv ----
// testbench for the serial sequence control register
`timescale 1ns/1ps
module serial_sequence_control_tb;
    import seq_ctrl_pkg::*;
    logic [7:0] addr = 0, wr_data = 0, loop_repeat_count = 0, rd_data, n;
    logic ref_clk = 0, link_clk = 0, rstn = 0, wr_en = 0, rd_en = 0;
    logic channel_on_bit = 0, trigger_in = 0, byte_done, seq_done, stop_seen;
    logic byte_count_pointer_clear, table_pointer_clear, channel_active;
    logic start_cmd, halt_byte_cmd, halt_seq_cmd;
    logic [31:0] rng = 85;
    int num_errors = 0, compares = 0, cycles = 0, starts = 0, seqs = 0, bps = 0, tps = 0;
    serial_sequence_control DUT (.ref_clk(ref_clk), .link_clk(link_clk), .rstn(rstn),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .channel_on_bit(channel_on_bit), .loop_repeat_count(loop_repeat_count),
        .trigger_in(trigger_in), .byte_count_pointer_clear(byte_count_pointer_clear),
        .table_pointer_clear(table_pointer_clear), .channel_active(channel_active),
        .byte_done(byte_done), .seq_done(seq_done), .stop_seen(stop_seen),
        .start_cmd(start_cmd), .halt_byte_cmd(halt_byte_cmd), .halt_seq_cmd(halt_seq_cmd));
    engine_model eng (.clk(link_clk), .rstn(rstn), .start_cmd(start_cmd),
        .halt_byte_cmd(halt_byte_cmd), .byte_done(byte_done), .seq_done(seq_done),
        .stop_seen(stop_seen));
    // clocks; link runs at a fifth of ref with a fixed 7 ns phase offset, so the domains never drift
    always #12.5 ref_clk = ~ref_clk;
    initial begin
        #7;
        forever #62.5 link_clk = ~link_clk;
    end
    // event tallies in each domain
    always @(posedge link_clk) begin
        if (start_cmd === 1'b1) starts++;
        if (seq_done === 1'b1) seqs++;
    end
    always @(posedge ref_clk) begin
        if (byte_count_pointer_clear === 1'b1) bps++;
        if (table_pointer_clear === 1'b1) tps++;
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            final_report;
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] d);
        addr <= CTRL_OFFSET;
        wr_data <= d;
        wr_en <= 1;
        @(posedge ref_clk);
        wr_en <= 0;
        @(posedge ref_clk);
    endtask
    task automatic rd(logic [7:0] exp);
        addr <= CTRL_OFFSET;
        rd_en <= 1;
        @(posedge ref_clk);
        rd_en <= 0;
        #1 chk("ctrl", rd_data, exp);
        @(posedge ref_clk);
    endtask
    // bounded wait for the channel to fall idle
    task automatic idle;
        repeat (3000) if (channel_active === 1'b1) @(posedge ref_clk);
        chk("active", 8'(channel_active), 8'h00);
    endtask
    task final_report;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        rstn <= 1;
        repeat (4) @(posedge ref_clk);
        // every host write keeps reserved bit 0 clear
        rd(CTRL_RESET);
        wr(8'h40);
        rd(8'h00);
        channel_on_bit <= 1;
        wr(8'hA0);
        rd(8'h00);
        wr(8'h04);
        wr(8'h02);
        rd(8'h00);
        chk("bptr", 8'(bps), 8'h01);
        chk("tptr", 8'(tps), 8'h01);
        // counted loops with a random count; trigger noise must not matter
        repeat (3) begin
            rng = xs(rng);
            n = 8'(rng % 3) + 8'h01;
            loop_repeat_count <= n;
            trigger_in <= rng[4];
            starts = 0;
            wr(8'h40);
            rd(8'h40);
            idle;
            chk("starts", 8'(starts), n);
            rd(8'h00);
        end
        loop_repeat_count <= LOOP_FOREVER;
        starts = 0;
        seqs = 0;
        wr(8'h40);
        wr(8'hA0);
        rd(8'hE0);
        // both halt bits stand well before the engine reaches its first byte; only the byte halt reaches the engine
        repeat (25) @(posedge ref_clk);
        chk("hbyte", 8'(halt_byte_cmd), 8'h01);
        chk("hseq", 8'(halt_seq_cmd), 8'h00);
        idle;
        chk("starts", 8'(starts), 8'h01);
        chk("seqs", 8'(seqs), 8'h00);
        rd(8'h00);
        starts = 0;
        wr(8'h40);
        wr(8'h80);
        repeat (25) @(posedge ref_clk);
        chk("hseq", 8'(halt_seq_cmd), 8'h01);
        idle;
        chk("starts", 8'(starts), 8'h01);
        chk("seqs", 8'(seqs), 8'h01);
        rd(8'h00);
        // trigger mode with both edge selections
        for (int e = 0; e < 2; e++) begin
            trigger_in <= e[0];
            starts = 0;
            wr(8'h48 | 8'(e << 4));
            trigger_in <= !e[0];
            repeat (60) @(posedge ref_clk);
            chk("starts", 8'(starts), 8'h01);
            repeat (150) @(posedge ref_clk);
            trigger_in <= e[0];
            repeat (60) @(posedge ref_clk);
            // halt while waiting; trigger setup is written back unchanged
            wr(8'h88 | 8'(e << 4));
            idle;
            chk("starts", 8'(starts), 8'h01);
            rd(8'h08 | 8'(e << 4));
        end
        final_report;
    end
endmodule
